//--- logic/tpc_timer.sv
// Timer with 16-bit counter, prescaler and capture, compare and PWM channels.
`timescale 1ns/1ps
module tpc_timer
	import tpc_pkg::*;
(
	// Clock and reset.
	input wire logic mclk,
	input wire logic nrst,
	// Register port.
	input wire logic [3:0] addr,
	input wire logic [7:0] wdata,
	input wire logic wr_en,
	input wire logic rd_en,
	output logic [7:0] rdata,
	// Processor modes.
	input wire logic debug_halt_mode,
	input wire logic stop_mode,
	// Count clocks.
	input wire logic fixed_clk_in,
	input wire logic external_count_clock,
	// Channel pins.
	input wire logic [TPC_NCH-1:0] channel_pin_in,
	output logic [TPC_NCH-1:0] channel_pin_out,
	output logic [TPC_NCH-1:0] channel_pin_oe,
	// Interrupt requests.
	output logic overflow_irq,
	output logic [TPC_NCH-1:0] channel_irq
);

	logic [1:0] rst_q;
	logic rst_n;
	logic [7:0] sc_reg;
	logic overflow_flag;
	logic ovf_arm_reg;
	logic [15:0] counter_value;
	logic [15:0] modulo_value;
	logic [6:0] presc_reg;
	logic down_reg;
	logic step_up_reg;
	logic upd_reg;
	logic [2:0] fix_q;
	logic [2:0] ext_q;
	logic src_tick;
	logic cnt_tick;
	logic wrap_ev;
	logic [15:0] top;
	logic cnt_wr;
	logic [7:0] rd_next;
	logic [1:0] clock_source_select;
	logic center_aligned_select;

	// Reset release through two flops keeps recovery timing clean.
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			rst_q <= 2'h0;
		end else begin
			rst_q <= {rst_q[0], 1'b1};
		end
	end
	assign rst_n = rst_q[1];

	assign clock_source_select = sc_reg[TPC_SC_CLKS +: 2];
	assign center_aligned_select = sc_reg[TPC_SC_CPWM];
	assign cnt_wr = wr_en && (addr == TPC_A_CNTH || addr == TPC_A_CNTL);
	// Modulo of zero or all ones gives the full 16-bit range.
	assign top = (modulo_value == TPC_MOD_RST) ? TPC_FULL : modulo_value; // RULE9

	// Slow clocks are synchronised and edge detected; only the second and third stages are used.
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			fix_q <= 3'h0;
			ext_q <= 3'h0;
		end else begin
			fix_q <= {fix_q[1:0], fixed_clk_in};
			ext_q <= {ext_q[1:0], external_count_clock};
		end
	end

	// Source selection; stop mode stands for halted input clocks.
	always_comb begin
		unique case (clock_source_select) // RULE22 RULE24
			TPC_CLK_NONE: src_tick = 1'b0;
			TPC_CLK_BUS: src_tick = 1'b1;
			TPC_CLK_FIX: src_tick = fix_q[1] && !fix_q[2];
			TPC_CLK_EXT: src_tick = ext_q[1] && !ext_q[2]; // RULE12
		endcase
		src_tick = src_tick && !stop_mode && !debug_halt_mode; // RULE2 RULE3
	end
	// The mask reads the register directly, so a new divide ratio acts next cycle.
	assign cnt_tick = src_tick && ((presc_reg & tpc_ps_mask(sc_reg[TPC_SC_PS +: 3])) ==
		tpc_ps_mask(sc_reg[TPC_SC_PS +: 3])); // RULE23 RULE25

	// Prescaler counts source ticks and is cleared with the counter.
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			presc_reg <= 7'h00;
		end else if (cnt_wr) begin
			presc_reg <= 7'h00;
		end else if (src_tick) begin
			presc_reg <= presc_reg + 7'h01;
		end
	end

	// Wrap event: top to zero when counting up only, one to zero on the down count when center-aligned.
	assign wrap_ev = cnt_tick && !cnt_wr && (center_aligned_select ?
		(down_reg && counter_value == 16'h0001) : (counter_value == top));

	// Main counter: up-only, or up/down while center-aligned is selected.
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			counter_value <= TPC_CNT_RST;
			down_reg <= 1'b0;
			step_up_reg <= 1'b1;
		end else if (cnt_wr) begin
			counter_value <= TPC_CNT_RST; // RULE10
			down_reg <= 1'b0;
			step_up_reg <= 1'b1;
		end else if (cnt_tick) begin
			if (!center_aligned_select) begin
				counter_value <= (counter_value == top) ? 16'h0000 : counter_value + 16'h0001;
				down_reg <= 1'b0; // RULE6
				step_up_reg <= 1'b1;
			end else if (!down_reg && counter_value < top) begin
				counter_value <= counter_value + 16'h0001; // RULE7 RULE21
				step_up_reg <= 1'b1;
			end else if (counter_value != 16'h0000) begin
				counter_value <= counter_value - 16'h0001;
				down_reg <= (counter_value != 16'h0001);
				step_up_reg <= 1'b0;
			end else begin
				counter_value <= 16'h0001;
				down_reg <= 1'b0;
				step_up_reg <= 1'b1;
			end
		end
	end

	// Marks the cycle in which a freshly counted value is present for matching.
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			upd_reg <= 1'b0;
		end else begin
			upd_reg <= cnt_tick && !cnt_wr;
		end
	end

	// Control register; the flag bit is handled apart and is never written to one.
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			sc_reg <= TPC_SC_RST; // RULE21
		end else if (wr_en && addr == TPC_A_SC) begin
			sc_reg <= {1'b0, wdata[6:0]};
		end
	end

	// Modulo bytes are written straight through; no coherency buffer is kept.
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			modulo_value <= TPC_MOD_RST;
		end else if (wr_en && addr == TPC_A_MODH) begin
			modulo_value[15:8] <= wdata;
		end else if (wr_en && addr == TPC_A_MODL) begin
			modulo_value[7:0] <= wdata;
		end
	end

	// Overflow flag: a read while set arms the clear, a new overflow wins and disarms.
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			overflow_flag <= 1'b0;
			ovf_arm_reg <= 1'b0;
		end else if (wrap_ev) begin
			overflow_flag <= 1'b1; // RULE18 RULE19
			ovf_arm_reg <= 1'b0;
		end else if (wr_en && addr == TPC_A_SC && !wdata[TPC_SC_OVF] && ovf_arm_reg) begin
			overflow_flag <= 1'b0; // RULE18
			ovf_arm_reg <= 1'b0;
		end else if (rd_en && addr == TPC_A_SC && overflow_flag) begin
			ovf_arm_reg <= 1'b1;
		end
	end

	// Overflow request follows flag and enable.
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			overflow_irq <= 1'b0;
		end else begin
			overflow_irq <= overflow_flag && sc_reg[TPC_SC_IE]; // RULE20
		end
	end

	// Per-channel state.
	// Bits 4:0 hold enable, mode and edge/level; the flag lives in its own register.
	logic [4:0] ch_ctl_reg [TPC_NCH];
	logic [15:0] channel_value [TPC_NCH];
	logic [TPC_NCH-1:0] ch_flag_reg;
	logic [TPC_NCH-1:0] ch_arm_reg;
	logic [TPC_NCH-1:0] cap_ev;
	logic [TPC_NCH-1:0] set_ev;
	logic [TPC_NCH-1:0] pin_act;

	for (genvar i = 0; i < TPC_NCH; i++) begin : g_ch
		localparam logic [3:0] BASE = 4'(TPC_A_CH0 + TPC_A_STRIDE * 4'(i));
		logic [2:0] in_q;
		logic [1:0] edge_level_select;
		tpc_mode_e md;
		logic match;
		logic ext_share;

		assign edge_level_select = ch_ctl_reg[i][TPC_CH_ELS - 2 +: 2];
		assign md = tpc_mode(center_aligned_select, ch_ctl_reg[i][TPC_CH_MS - 2 +: 2]); // RULE1 RULE14
		assign ext_share = (i == TPC_EXT_CH) && (clock_source_select == TPC_CLK_EXT);
		// Pin is released on zero edge/level, no clock, or a shared external clock.
		assign pin_act[i] = (edge_level_select != 2'h0) && (clock_source_select != TPC_CLK_NONE)
			&& !ext_share; // RULE11 RULE13
		assign match = upd_reg && counter_value == channel_value[i];

		// Two synchronising stages, a third for edge detection.
		always_ff @(posedge mclk or negedge rst_n) begin
			if (!rst_n) begin
				in_q <= 3'h0;
			end else begin
				in_q <= {in_q[1:0], channel_pin_in[i]}; // RULE15
			end
		end

		// Capture edge decode; disabled outside input capture mode.
		assign cap_ev[i] = pin_act[i] && md == TPC_IC && (
			(edge_level_select[0] && in_q[1] && !in_q[2]) ||
			(edge_level_select[1] && !in_q[1] && in_q[2])); // RULE26
		// Compare runs on with no pin action, which is the software timer use.
		assign set_ev[i] = cap_ev[i] || (match && md != TPC_IC &&
			(md == TPC_OC || edge_level_select != 2'h0)); // RULE5 RULE11

		// Control fields of the channel.
		always_ff @(posedge mclk or negedge rst_n) begin
			if (!rst_n) begin
				ch_ctl_reg[i] <= 5'h00;
			end else if (wr_en && addr == BASE) begin
				ch_ctl_reg[i] <= wdata[6:2];
			end
		end

		// Value register: capture loads it, software may not write it during capture.
		always_ff @(posedge mclk or negedge rst_n) begin
			if (!rst_n) begin
				channel_value[i] <= TPC_CV_RST;
			end else if (cap_ev[i]) begin
				channel_value[i] <= counter_value; // RULE4
			end else if (wr_en && addr == BASE + 4'h1 && md != TPC_IC) begin
				channel_value[i][15:8] <= wdata;
			end else if (wr_en && addr == BASE + 4'h2 && md != TPC_IC) begin
				channel_value[i][7:0] <= wdata;
			end
		end

		// Channel flag with the same read-then-write-zero clear as the overflow flag.
		always_ff @(posedge mclk or negedge rst_n) begin
			if (!rst_n) begin
				ch_flag_reg[i] <= 1'b0;
				ch_arm_reg[i] <= 1'b0;
			end else if (set_ev[i]) begin
				ch_flag_reg[i] <= 1'b1; // RULE4 RULE5
				ch_arm_reg[i] <= 1'b0;
			end else if (wr_en && addr == BASE && !wdata[TPC_CH_FLAG] && ch_arm_reg[i]) begin
				ch_flag_reg[i] <= 1'b0;
				ch_arm_reg[i] <= 1'b0;
			end else if (rd_en && addr == BASE && ch_flag_reg[i]) begin
				ch_arm_reg[i] <= 1'b1;
			end
		end

		// Pin level; it holds its value across mode changes, so toggle starts from it.
		always_ff @(posedge mclk or negedge rst_n) begin
			if (!rst_n) begin
				channel_pin_out[i] <= 1'b0;
			end else if (pin_act[i] && upd_reg) begin
				unique case (md)
					TPC_IC: channel_pin_out[i] <= channel_pin_out[i];
					TPC_OC: begin
						if (match) begin
							unique case (edge_level_select) // RULE27
								2'h1: channel_pin_out[i] <= !channel_pin_out[i]; // RULE16
								2'h2: channel_pin_out[i] <= 1'b0;
								2'h3: channel_pin_out[i] <= 1'b1;
								default: channel_pin_out[i] <= channel_pin_out[i];
							endcase
						end
					end
					TPC_EPWM: begin
						// A match at zero wins, giving a steady inactive level.
						if (match) begin
							channel_pin_out[i] <= edge_level_select[0]; // RULE17
						end else if (counter_value == 16'h0000) begin
							channel_pin_out[i] <= !edge_level_select[0]; // RULE6
						end
					end
					TPC_CPWM: begin
						if (match) begin
							channel_pin_out[i] <= edge_level_select[0] ^ !step_up_reg; // RULE8
						end
					end
				endcase
			end
		end

		// Output enable and interrupt request per channel.
		always_ff @(posedge mclk or negedge rst_n) begin
			if (!rst_n) begin
				channel_pin_oe[i] <= 1'b0;
				channel_irq[i] <= 1'b0;
			end else begin
				channel_pin_oe[i] <= pin_act[i] && md != TPC_IC; // RULE13
				channel_irq[i] <= ch_flag_reg[i] && ch_ctl_reg[i][TPC_CH_IE - 2];
			end
		end
	end

	// Read mux; reads never touch counting, unmapped addresses read zero.
	always_comb begin
		rd_next = 8'h00;
		unique case (addr)
			TPC_A_SC: rd_next = {overflow_flag, sc_reg[6:0]};
			TPC_A_CNTH: rd_next = counter_value[15:8]; // RULE10
			TPC_A_CNTL: rd_next = counter_value[7:0];
			TPC_A_MODH: rd_next = modulo_value[15:8];
			TPC_A_MODL: rd_next = modulo_value[7:0];
			default: begin
				for (int k = 0; k < TPC_NCH; k++) begin
					if (addr == 4'(TPC_A_CH0 + TPC_A_STRIDE * 4'(k))) begin
						rd_next = {ch_flag_reg[k], ch_ctl_reg[k], 2'b00};
					end else if (addr == 4'(TPC_A_CH0 + TPC_A_STRIDE * 4'(k) + 4'h1)) begin
						rd_next = channel_value[k][15:8];
					end else if (addr == 4'(TPC_A_CH0 + TPC_A_STRIDE * 4'(k) + 4'h2)) begin
						rd_next = channel_value[k][7:0];
					end
				end
			end
		endcase
	end

	// Read data stand in the cycle after the strobe only.
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			rdata <= 8'h00;
		end else begin
			rdata <= rd_en ? rd_next : 8'h00;
		end
	end

	// Checks kept beside the logic.
	a_halt_freezes_count: assert property (@(posedge mclk) disable iff (!rst_n) // RULE2
		debug_halt_mode && !cnt_wr |=> $stable(counter_value))
		else $error("Counter moved during debug halt.");

	a_cnt_write_clears: assert property (@(posedge mclk) disable iff (!rst_n) // RULE10
		cnt_wr |=> counter_value == 16'h0000 && presc_reg == 7'h00)
		else $error("Counter write did not clear the count.");

	a_ovf_flag_holds: assert property (@(posedge mclk) disable iff (!rst_n) // RULE18
		overflow_flag && !(wr_en && addr == TPC_A_SC && !wdata[TPC_SC_OVF]) |=> overflow_flag)
		else $error("Overflow flag dropped without a clear write.");

	a_ovf_set_wins: assert property (@(posedge mclk) disable iff (!rst_n) // RULE19
		wrap_ev |=> overflow_flag && !ovf_arm_reg)
		else $error("Overflow lost or clear sequence not restarted.");

	a_ovf_irq_follows: assert property (@(posedge mclk) disable iff (!rst_n) // RULE20
		overflow_flag && sc_reg[TPC_SC_IE] |=> overflow_irq)
		else $error("Overflow request missing.");

	a_free_run_wrap: assert property (@(posedge mclk) disable iff (!rst_n) // RULE9
		cnt_tick && !cnt_wr && !center_aligned_select && counter_value != TPC_FULL &&
		(modulo_value == TPC_MOD_RST || modulo_value == TPC_FULL) |=>
		counter_value == $past(counter_value) + 16'h0001)
		else $error("Free-running counter wrapped early.");

	a_center_no_capture: assert property (@(posedge mclk) disable iff (!rst_n) // RULE1
		center_aligned_select |-> cap_ev == '0)
		else $error("Capture while center-aligned.");

	a_capture_value: assert property (@(posedge mclk) disable iff (!rst_n) // RULE4
		cap_ev[1] |=> channel_value[1] == $past(counter_value) && ch_flag_reg[1])
		else $error("Capture did not load counter value.");

	a_pin_release: assert property (@(posedge mclk) disable iff (!rst_n) // RULE13
		clock_source_select == TPC_CLK_NONE ##1 clock_source_select == TPC_CLK_NONE
		|=> channel_pin_oe == '0)
		else $error("Pin driven with no clock selected.");

endmodule : tpc_timer

//--- logic/tpc_pkg.sv
// Constants, types and helper functions for the timer with capture, compare and PWM channels.
//
// Notes on behaviour
// RULE1 - One module-wide bit forces all channels into center-aligned PWM only.
// RULE2 - Debug halt mode freezes all counting until normal operation returns.
// RULE3 - Wait mode changes nothing; stop mode halts input clocks, timer idles.
// RULE4 - Input capture copies the 16-bit counter into channel value, sets channel flag.
// RULE5 - Output compare match sets channel flag and clears, sets, toggles or ignores pin.
// RULE6 - Edge-aligned PWM period is modulo plus one; channel value sets the duty.
// RULE7 - Center-aligned PWM counts up to modulo then down to zero.
// RULE8 - Center-aligned high-true clears on up-count match, sets on down-count match.
// RULE9 - Modulo all zeros or all ones makes the counter run its full range.
// RULE10 - Counter reads are harmless; any counter byte write clears the counter.
// RULE11 - External clock on a channel pin leaves that channel software compare only.
// RULE12 - External clock must stay below a quarter of the bus clock.
// RULE13 - Pin released when edge/level field is zero or clock source is zero.
// RULE14 - Mode field 00 capture, 01 compare, 1x edge PWM; each needs nonzero edge/level.
// RULE15 - Capture inputs are synchronised; four-cycle pulses are always caught.
// RULE16 - Toggle compare keeps the old pin level until the next match.
// RULE17 - Edge PWM high-true goes high at zero, low on match; low-true opposite.
// RULE18 - Overflow flag bit 7 sets on wrap; read-while-set then write zero clears.
// RULE19 - A new overflow during the clear sequence restarts it; flag stays set.
// RULE20 - Overflow interrupt enable bit 6 raises the request while the flag is set.
// RULE21 - Center-aligned select bit 5 switches counting to up/down; reset clears it.
// RULE22 - Clock source field bits 4-3 disables counting or picks one of three clocks.
// RULE23 - Prescale field bits 2-0 takes effect the bus cycle after the write.
// RULE24 - Clock codes: 00 none, 01 bus, 10 fixed-frequency, 11 external.
// RULE25 - Prescale value k divides the selected clock by two to the power k.
// RULE26 - Capture edge codes: 01 rising, 10 falling, 11 both edges.
// RULE27 - Compare codes: 00 no pin, 01 toggle, 10 clear, 11 set on match.
package tpc_pkg;
	localparam int TPC_NCH = 2;
	localparam int TPC_EXT_CH = 0;
	localparam logic [3:0] TPC_A_SC = 4'h0;
	localparam logic [3:0] TPC_A_CNTH = 4'h1;
	localparam logic [3:0] TPC_A_CNTL = 4'h2;
	localparam logic [3:0] TPC_A_MODH = 4'h3;
	localparam logic [3:0] TPC_A_MODL = 4'h4;
	localparam logic [3:0] TPC_A_CH0 = 4'h5;
	localparam logic [3:0] TPC_A_STRIDE = 4'h3;
	localparam int TPC_SC_OVF = 7;
	localparam int TPC_SC_IE = 6;
	localparam int TPC_SC_CPWM = 5;
	localparam int TPC_SC_CLKS = 3;
	localparam int TPC_SC_PS = 0;
	localparam int TPC_CH_FLAG = 7;
	localparam int TPC_CH_IE = 6;
	localparam int TPC_CH_MS = 4;
	localparam int TPC_CH_ELS = 2;
	localparam logic [1:0] TPC_CLK_NONE = 2'h0;
	localparam logic [1:0] TPC_CLK_BUS = 2'h1;
	localparam logic [1:0] TPC_CLK_FIX = 2'h2;
	localparam logic [1:0] TPC_CLK_EXT = 2'h3;
	localparam logic [7:0] TPC_SC_RST = 8'h00;
	localparam logic [15:0] TPC_CNT_RST = 16'h0000;
	localparam logic [15:0] TPC_MOD_RST = 16'h0000;
	localparam logic [15:0] TPC_CV_RST = 16'h0000;
	localparam logic [15:0] TPC_FULL = 16'hffff;

	typedef enum logic [1:0] {TPC_IC, TPC_OC, TPC_EPWM, TPC_CPWM} tpc_mode_e;

	// Channel function from the module-wide select and the channel mode field.
	function automatic tpc_mode_e tpc_mode(input logic cpwm, input logic [1:0] ms);
		if (cpwm) begin
			return TPC_CPWM;
		end else if (ms[1]) begin
			return TPC_EPWM;
		end else if (ms[0]) begin
			return TPC_OC;
		end
		return TPC_IC;
	endfunction : tpc_mode

	// Low-bit mask of the prescaler that must be all ones for a divided tick.
	function automatic logic [6:0] tpc_ps_mask(input logic [2:0] ps);
		return 7'((8'h01 << ps) - 8'h01);
	endfunction : tpc_ps_mask
endpackage : tpc_pkg

//--- testbench/tpc_far_model.sv
// Model of the outside world at the timer: channel pin levels and the two count clocks.
`timescale 1ns/1ps
module tpc_far_model (
	// Clock.
	input wire logic mclk,
	// Levels seen by the timer.
	output logic [1:0] far_pin,
	output logic ext_clk,
	output logic fix_clk
);
	// Everything idles low at time zero; the count clocks stand still outside bursts.
	initial begin
		far_pin = 2'h0;
		ext_clk = 1'b0;
		fix_clk = 1'b0;
	end

	// A new pin level is held at least four cycles so that the synchroniser cannot miss it.
	task automatic set_pin(input int ch, input logic lvl);
		@(posedge mclk);
		far_pin[ch] <= lvl;
		repeat (4) @(posedge mclk);
	endtask : set_pin

	// Clock bursts with a period of eight cycles, well below a quarter of the bus rate.
	task automatic pulses(input logic use_ext, input int n);
		repeat (n) begin
			@(posedge mclk);
			if (use_ext) ext_clk <= 1'b1;
			else fix_clk <= 1'b1;
			repeat (4) @(posedge mclk);
			ext_clk <= 1'b0;
			fix_clk <= 1'b0;
			repeat (3) @(posedge mclk);
		end
	endtask : pulses
endmodule : tpc_far_model

//--- testbench/tb_top.sv
// Self-checking testbench for the timer with capture, compare and PWM channels.
`timescale 1ns/1ps
module tb_top
	import tpc_pkg::*;
;
	localparam logic [3:0] C1 = TPC_A_CH0 + TPC_A_STRIDE;
	logic mclk = 1'b0;
	logic nrst = 1'b0;
	logic [3:0] addr = 4'h0;
	logic [7:0] wdata = 8'h00;
	logic wr_en = 1'b0;
	logic rd_en = 1'b0;
	logic [7:0] rdata;
	logic debug_halt_mode = 1'b0;
	logic stop_mode = 1'b0;
	logic [1:0] channel_pin_in;
	logic [1:0] channel_pin_out;
	logic [1:0] channel_pin_oe;
	logic [1:0] far_pin;
	logic [1:0] channel_irq;
	logic overflow_irq;
	logic ext_clk;
	logic fix_clk;
	int mismatches = 0;
	int comparisons = 0;

	// Clock of 200 MHz.
	always #2.5 mclk = ~mclk;

	// The pin wire follows the timer while it drives, else the outside level.
	assign channel_pin_in = (channel_pin_oe & channel_pin_out) | (~channel_pin_oe & far_pin);

	tpc_timer dut (.mclk(mclk), .nrst(nrst), .addr(addr), .wdata(wdata), .wr_en(wr_en),
		.rd_en(rd_en), .rdata(rdata), .debug_halt_mode(debug_halt_mode),
		.stop_mode(stop_mode), .fixed_clk_in(fix_clk), .external_count_clock(ext_clk),
		.channel_pin_in(channel_pin_in), .channel_pin_out(channel_pin_out),
		.channel_pin_oe(channel_pin_oe), .overflow_irq(overflow_irq),
		.channel_irq(channel_irq));

	tpc_far_model far (.mclk(mclk), .far_pin(far_pin), .ext_clk(ext_clk), .fix_clk(fix_clk));

	// Compares one value and reports a difference at once.
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		comparisons++;
		if (seen !== exp) begin
			mismatches++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk

	task automatic tick(input int n);
		repeat (n) @(posedge mclk);
	endtask : tick

	// One-cycle write strobe beside address and data.
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge mclk);
		addr <= a;
		wdata <= d;
		wr_en <= 1'b1;
		@(posedge mclk);
		wr_en <= 1'b0;
	endtask : wr

	// One-cycle read strobe; the data stand only in the following cycle.
	task automatic rd(input logic [3:0] a, output logic [7:0] d);
		@(posedge mclk);
		addr <= a;
		rd_en <= 1'b1;
		@(posedge mclk);
		rd_en <= 1'b0;
		@(posedge mclk);
		d = rdata;
	endtask : rd

	// Sixteen-bit values travel high byte first, at the lower address.
	task automatic wr16(input logic [3:0] a, input logic [15:0] v);
		wr(a, v[15:8]);
		wr(a + 4'h1, v[7:0]);
	endtask : wr16

	task automatic rd16(input logic [3:0] a, output logic [15:0] v);
		logic [7:0] h;
		logic [7:0] l;
		rd(a, h);
		rd(a + 4'h1, l);
		v = {h, l};
	endtask : rd16

	function automatic logic [7:0] scb(input logic ie, input logic cp, input logic [1:0] ck,
		input logic [2:0] ps);
		return {1'b0, ie, cp, ck, ps};
	endfunction : scb

	function automatic logic [7:0] csc(input logic ie, input logic [1:0] ms, input logic [1:0] el);
		return {1'b0, ie, ms, el, 2'b00};
	endfunction : csc

	// Counts the cycles in which channel 1 drives high over a whole number of periods.
	task automatic count_high(input int n, output logic [15:0] hi);
		hi = 16'h0000;
		repeat (n) begin
			@(posedge mclk);
			if (channel_pin_out[1] === 1'b1) hi++;
		end
	endtask : count_high

	task automatic give_verdict();
		$display("comparisons %0d, mismatches %0d", comparisons, mismatches);
		if (mismatches == 0 && comparisons > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask : give_verdict

	// A hang is cut short well beyond the fewer than two thousand cycles the tests need.
	initial begin
		repeat (30000) @(posedge mclk);
		mismatches++;
		$display("watchdog expired");
		give_verdict();
	end

	// Main sequence of tests.
	initial begin
		logic [7:0] b;
		logic [15:0] v;
		logic [1:0] e;
		logic px;
		logic prev;
		repeat (8) @(posedge mclk);
		nrst <= 1'b1;
		tick(3);
		for (int a = 0; a < 11; a++) begin
			rd(4'(a), b);
			chk(b, 8'h00);
		end
		rd(4'hf, b);
		chk(b, 8'h00);
		$display("test reset values done");
		// Overflow flag: set on wrap, write of one ignored, cleared by read then zero.
		wr16(TPC_A_MODH, 16'h0002);
		wr(TPC_A_SC, scb(1'b1, 1'b0, TPC_CLK_BUS, 3'h0));
		tick(10);
		wr(TPC_A_SC, 8'hc0);
		rd(TPC_A_SC, b);
		chk(b, 8'hc0);
		chk(overflow_irq, 1'b1);
		rd(TPC_A_SC, b);
		wr(TPC_A_SC, 8'h40);
		rd(TPC_A_SC, b);
		chk(b, 8'h40);
		chk(overflow_irq, 1'b0);
		// An overflow lands between the arming read and the clearing write.
		wr(TPC_A_SC, scb(1'b0, 1'b0, TPC_CLK_BUS, 3'h0));
		tick(4);
		rd(TPC_A_SC, b);
		wr(TPC_A_SC, scb(1'b0, 1'b0, TPC_CLK_BUS, 3'h0));
		wr(TPC_A_SC, 8'h00);
		rd(TPC_A_SC, b);
		chk(b, 8'h80);
		$display("test overflow flag done");
		// Full-range modulo settings and counter clearing.
		for (int m = 0; m < 2; m++) begin
			wr16(TPC_A_MODH, m ? TPC_FULL : 16'h0000);
			wr(TPC_A_CNTH, 8'ha5);
			wr(TPC_A_SC, scb(1'b0, 1'b0, TPC_CLK_BUS, 3'h0));
			tick(20);
			wr(TPC_A_SC, 8'h00);
			rd16(TPC_A_CNTH, v);
			chk(v > 16'h000f && v < 16'h0019, 1'b1);
			wr(TPC_A_CNTL, 8'h5a);
			rd16(TPC_A_CNTH, v);
			chk(v, 16'h0000);
		end
		// Debug halt, then stop mode, each freeze and then release counting.
		for (int k = 0; k < 2; k++) begin
			@(posedge mclk);
			if (k == 0) debug_halt_mode <= 1'b1;
			else stop_mode <= 1'b1;
			wr(TPC_A_CNTL, 8'h00);
			wr(TPC_A_SC, scb(1'b0, 1'b0, TPC_CLK_BUS, 3'h0));
			tick(20);
			rd16(TPC_A_CNTH, v);
			chk(v, 16'h0000);
			debug_halt_mode <= 1'b0;
			stop_mode <= 1'b0;
			tick(20);
			wr(TPC_A_SC, 8'h00);
			rd16(TPC_A_CNTH, v);
			chk(v != 16'h0000, 1'b1);
		end
		// Prescaler divides by four, eight and sixteen: five ticks each.
		for (int p = 2; p < 5; p++) begin
			wr(TPC_A_CNTL, 8'h00);
			wr(TPC_A_SC, scb(1'b0, 1'b0, TPC_CLK_BUS, 3'(p)));
			tick((5 << p) + (1 << (p - 1)) - 2);
			wr(TPC_A_SC, 8'h00);
			rd16(TPC_A_CNTH, v);
			chk(v, 16'h0005);
		end
		$display("test counter done");
		// Output compare on channel 1 with set, clear, toggle and no pin action.
		wr16(TPC_A_MODH, 16'h0010);
		prev = 1'b0;
		for (int i = 0; i < 4; i++) begin
			e = 2'(3 - i);
			wr(TPC_A_SC, 8'h00);
			wr(TPC_A_CNTL, 8'h00);
			rd(C1, b);
			wr(C1, csc(1'b1, 2'b01, e));
			if (i == 0) wr16(C1 + 4'h1, 16'h0005);
			wr(TPC_A_SC, scb(1'b0, 1'b0, TPC_CLK_BUS, 3'h0));
			tick(2);
			if (e == 2'b01) chk(channel_pin_out[1], prev);
			tick(10);
			chk(channel_pin_oe[1], e != 2'b00);
			wr(TPC_A_SC, 8'h00);
			rd(C1, b);
			chk(b[7], 1'b1);
			chk(channel_irq[1], 1'b1);
			chk(channel_pin_oe[1], 1'b0);
			px = (e == 2'b11) ? 1'b1 : (e == 2'b10) ? 1'b0 : ~prev;
			if (e != 2'b00) chk(channel_pin_out[1], px);
			prev = px;
		end
		$display("test output compare done");
		// Edge-aligned, then center-aligned PWM, both polarities, period 9 and 16.
		wr16(TPC_A_MODH, 16'h0008);
		for (int c = 0; c < 4; c++) begin
			e = (c % 2 == 0) ? 2'b10 : 2'b01;
			wr(TPC_A_SC, 8'h00);
			wr(TPC_A_CNTL, 8'h00);
			wr(C1, csc(1'b0, (c < 2) ? 2'b10 : 2'b00, e));
			wr(TPC_A_SC, scb(1'b0, c >= 2, TPC_CLK_BUS, 3'h0));
			tick(40);
			count_high((c < 2) ? 18 : 32, v);
			chk(channel_pin_oe[1], 1'b1);
			if (c < 2) chk(v, (e == 2'b10) ? 16'd10 : 16'd8);
			else chk(v, (e == 2'b10) ? 16'd20 : 16'd12);
		end
		$display("test pwm done");
		// Fixed and external clock sources; channel 0 shares the external clock pin.
		wr(TPC_A_SC, 8'h00);
		wr(TPC_A_CH0, csc(1'b0, 2'b01, 2'b11));
		wr16(TPC_A_CH0 + 4'h1, 16'h0003);
		for (int s = 2; s < 4; s++) begin
			wr(TPC_A_SC, 8'h00);
			wr(TPC_A_CNTL, 8'h00);
			rd(TPC_A_CH0, b);
			wr(TPC_A_CH0, csc(1'b0, 2'b01, 2'b11));
			wr(TPC_A_SC, scb(1'b0, 1'b0, 2'(s), 3'h0));
			far.pulses(s == 3, 6);
			tick(4);
			chk(channel_pin_oe[0], s == 2);
			wr(TPC_A_SC, 8'h00);
			rd16(TPC_A_CNTH, v);
			chk(v, 16'h0006);
			rd(TPC_A_CH0, b);
			chk(b[7], 1'b1);
		end
		$display("test clock sources done");
		// Capture on channel 1 with the counter frozen at three by debug halt.
		wr16(TPC_A_MODH, 16'h0000);
		wr(TPC_A_CNTL, 8'h00);
		wr(C1, csc(1'b0, 2'b00, 2'b01));
		wr(TPC_A_SC, scb(1'b0, 1'b0, TPC_CLK_BUS, 3'h7));
		tick(450);
		debug_halt_mode <= 1'b1;
		for (int i = 1; i < 4; i++) begin
			e = 2'(i);
			rd(C1, b);
			wr(C1, csc(1'b1, 2'b00, e));
			far.set_pin(1, 1'b1);
			rd(C1, b);
			chk(b[7], e[0]);
			wr(C1, csc(1'b1, 2'b00, e));
			far.set_pin(1, 1'b0);
			rd(C1, b);
			chk(b[7], e[1]);
		end
		chk(channel_irq[1], 1'b1);
		wr16(C1 + 4'h1, 16'h1234);
		rd16(C1 + 4'h1, v);
		chk(v, 16'h0003);
		debug_halt_mode <= 1'b0;
		$display("test input capture done");
		give_verdict();
	end
endmodule : tb_top
